// ### include/uartsf_pkg.sv
// Constants and carrier types for the UART status and flow-threshold block.
// Assumes the register port presents a 4-bit offset and 8-bit data.
package uartsf_pkg;

  // Register offsets
  localparam logic [3:0] UARTSF_OFS_SECOND_RESUME_CHAR = 4'h5;
  localparam logic [3:0] UARTSF_OFS_LSR = 4'h5;
  localparam logic [3:0] UARTSF_OFS_MSR = 4'h6;
  localparam logic [3:0] UARTSF_OFS_TCR = 4'h6;

  // Selection values and bit positions of the surrounding control registers
  localparam logic [7:0] UARTSF_LCR_ENH_KEY = 8'hBF;
  localparam int UARTSF_LCR_DLAB_BIT = 7;
  localparam int UARTSF_MCR_DTR_BIT = 0;
  localparam int UARTSF_MCR_RTS_BIT = 1;
  localparam int UARTSF_MCR_OP1_BIT = 2;
  localparam int UARTSF_MCR_OP2_BIT = 3;
  localparam int UARTSF_MCR_LOOP_BIT = 4;
  localparam int UARTSF_SFR_SEL_BIT = 2;
  localparam int UARTSF_EFR_ENH_BIT = 4;

  // Line status bit positions
  localparam int UARTSF_LSR_ERR_BIT = 7;
  localparam int UARTSF_LSR_BRK_BIT = 4;
  localparam int UARTSF_LSR_FE_BIT = 3;
  localparam int UARTSF_LSR_PE_BIT = 2;
  localparam int UARTSF_LSR_OE_BIT = 1;
  localparam int UARTSF_LSR_DR_BIT = 0;

  // Modem status bit positions (delta flags occupy 3:0)
  localparam int UARTSF_MSR_CD_BIT = 7;
  localparam int UARTSF_MSR_RI_BIT = 6;
  localparam int UARTSF_MSR_DSR_BIT = 5;
  localparam int UARTSF_MSR_CTS_BIT = 4;

  // Reset values and level scaling
  localparam logic [7:0] UARTSF_SECOND_RESUME_CHAR_RST = 8'h00;
  localparam logic [7:0] UARTSF_TCR_RST = 8'h00;
  localparam logic [7:0] UARTSF_MSR_RST = 8'h00;
  localparam int UARTSF_LEVEL_SHIFT = 2;
  localparam int UARTSF_FIFO_DEPTH = 64;

  // Per-character receive error indications
  typedef struct packed {
    logic brk;
    logic fe;
    logic pe;
  } uartsf_rxerr_t;

  // Modem line status, active high
  typedef struct packed {
    logic cd;
    logic ri;
    logic dsr;
    logic cts;
  } uartsf_modem_t;

  // Surrounding control register values
  typedef struct packed {
    logic [7:0] line_control_reg;
    logic [7:0] modem_control_reg;
    logic [7:0] special_feature_reg;
    logic [7:0] enhanced_feature_reg;
  } uartsf_ctrl_t;

endpackage : uartsf_pkg

// ### verilog/uartsf_err_track.sv
// Receive error tracker: mirrors the receive FIFO occupancy and per-entry flags.
// Assumes push and pop strobes match the external receive FIFO one for one.
`timescale 1ns/100ps
module uartsf_err_track #(
  parameter int DEPTH = uartsf_pkg::UARTSF_FIFO_DEPTH,
  parameter int CW = $clog2(DEPTH + 1)
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic sw_rst,
  input wire logic push,
  input wire uartsf_pkg::uartsf_rxerr_t push_err,
  input wire logic pop,
  output logic push_ok,
  output logic full,
  output logic [CW-1:0] count,
  output uartsf_pkg::uartsf_rxerr_t head_err,
  output logic any_err
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CW-1:0] cnt;
    logic [CW-1:0] ecnt;
  } uartsf_et_st_t;

  uartsf_et_st_t st_reg;
  uartsf_et_st_t st_next;
  uartsf_pkg::uartsf_rxerr_t mem [DEPTH];
  logic do_pop;

  assign full = (st_reg.cnt == CW'(DEPTH));
  assign push_ok = push && !full;
  assign do_pop = pop && (st_reg.cnt != '0);
  assign count = st_reg.cnt;
  assign head_err = (st_reg.cnt != '0) ? mem[st_reg.rp] : '0;
  assign any_err = (st_reg.ecnt != '0);

  always_comb begin
    st_next = st_reg;
    if (push_ok) begin
      st_next.wp = (st_reg.wp == AW'(DEPTH - 1)) ? '0 : st_reg.wp + 1'b1;
    end
    if (do_pop) begin
      st_next.rp = (st_reg.rp == AW'(DEPTH - 1)) ? '0 : st_reg.rp + 1'b1;
    end
    st_next.cnt = st_reg.cnt + CW'(push_ok) - CW'(do_pop);
    st_next.ecnt = st_reg.ecnt + CW'(push_ok && (|push_err)) - CW'(do_pop && (|head_err));
    if (sw_rst) begin
      st_next = '0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Flags stored beside each entry
  always_ff @(posedge clk) begin
    if (push_ok) begin
      mem[st_reg.wp] <= push_err; // RQ21
    end
  end
endmodule : uartsf_err_track

// ### verilog/uartsf_msr_delta.sv
// Modem status delta flags: edge detection with clear on status read.
// Assumes line inputs are already synchronous and loopback-mapped.
`timescale 1ns/100ps
module uartsf_msr_delta (
  input wire logic clk,
  input wire logic rst,
  input wire logic sw_rst,
  input wire uartsf_pkg::uartsf_modem_t lines,
  input wire logic clr,
  output logic [3:0] delta
);
  typedef struct packed {
    uartsf_pkg::uartsf_modem_t prev;
    logic [3:0] dlt;
  } uartsf_md_st_t;

  uartsf_md_st_t st_reg;
  uartsf_md_st_t st_next;
  logic [3:0] set;

  always_comb begin
    set[3] = lines.cd ^ st_reg.prev.cd; // RQ12
    set[2] = st_reg.prev.ri && !lines.ri; // RQ13
    set[1] = lines.dsr ^ st_reg.prev.dsr; // RQ14
    set[0] = lines.cts ^ st_reg.prev.cts; // RQ14
    st_next.prev = lines;
    st_next.dlt = (clr ? 4'h0 : st_reg.dlt) | set; // RQ22
    if (sw_rst) begin
      st_next = '0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign delta = st_reg.dlt;
endmodule : uartsf_msr_delta

// ### verilog/uartsf_status.sv
// UART receive status, modem status and receive flow-threshold logic.
// Assumes the receive FIFO core, transmitter and control registers live outside.
// Functional notes
// [RQ1] Line status bit 3 shows framing error of the character at read position.
// [RQ2] Line status bit 2 shows parity error of the character at read position.
// [RQ3] Line status bit 1 flags a character arriving at full FIFO; it is dropped.
// [RQ4] Line status bit 0 is one while the receive FIFO holds any character.
// [RQ5] Second resume character register, read/write, selected when key value and feature bit allow.
// [RQ6] Second resume character clears only on power-on reset, not software reset.
// [RQ7] Modem status at offset 6 when control bits 7, 2 and feature bit are zero.
// [RQ8] Status bit 7 is inverted carrier detect, or modem control bit 3 in loopback.
// [RQ9] Status bit 6 is inverted ring indicator, or modem control bit 2 in loopback.
// [RQ10] Status bit 5 is inverted data-set-ready, or modem control bit 0 in loopback.
// [RQ11] Status bit 4 is inverted clear-to-send, or modem control bit 1 in loopback.
// [RQ12] Status bit 3 sets on any carrier-detect change and raises the modem interrupt.
// [RQ13] Status bit 2 sets only when ring indicator input goes low to high.
// [RQ14] Status bits 1 and 0 set on data-set-ready and clear-to-send changes.
// [RQ15] Halt/resume level register shares offset 6, selected by enhanced mode and bit 2.
// [RQ16] At or below four times resume level, reassert RTS or send resume character.
// [RQ17] At or above four times halt level, deassert RTS or send halt character; a zero halt level never halts.
// [RQ18] Software should keep resume below and halt above the receive trigger level.
// [RQ19] Modem control bit 4 selects loopback, routing control bits into status.
// [RQ20] Line status bit 7 is one while any FIFO character carries an error.
// [RQ21] Error indications are stored with each FIFO entry.
// [RQ22] Reading modem status clears the four delta flags.
`timescale 1ns/100ps
module uartsf_status #(
  parameter int DEPTH = uartsf_pkg::UARTSF_FIFO_DEPTH
) (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic SW_RESET,
  input wire logic [3:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  input wire uartsf_pkg::uartsf_ctrl_t CTRL,
  input wire logic RX_PUSH,
  input wire uartsf_pkg::uartsf_rxerr_t RX_PUSH_ERR,
  input wire logic RX_POP,
  output logic RX_PUSH_OK,
  input wire logic CD_N,
  input wire logic RI_N,
  input wire logic DSR_N,
  input wire logic CTS_N,
  input wire logic MSR_IRQ_EN,
  output logic MSR_IRQ,
  input wire logic AUTO_RTS_EN,
  input wire logic AUTO_SWFLOW_EN,
  output logic RTS_N,
  output logic XOFF_SEND,
  output logic XON_SEND,
  output logic [7:0] SECOND_RESUME_CHAR
);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [7:0] rdata;
    logic [7:0] second_resume_char;
    logic [7:0] rx_halt_resume_levels;
    logic overrun;
    logic halted;
    logic rts_n;
    logic xon_p;
    logic xoff_p;
    logic irq;
  } uartsf_st_t;

  localparam uartsf_st_t ST_RST = '{
    rdata: 8'h00,
    second_resume_char: uartsf_pkg::UARTSF_SECOND_RESUME_CHAR_RST,
    rx_halt_resume_levels: uartsf_pkg::UARTSF_TCR_RST,
    overrun: 1'b0,
    halted: 1'b0,
    rts_n: 1'b1,
    xon_p: 1'b0,
    xoff_p: 1'b0,
    irq: 1'b0
  };

  uartsf_st_t st_reg;
  uartsf_st_t st_next;

  logic fifo_full;
  logic [CW-1:0] fifo_cnt;
  uartsf_pkg::uartsf_rxerr_t head_err;
  logic any_err;
  logic [3:0] delta;
  uartsf_pkg::uartsf_modem_t lines;
  logic loopback;
  logic enh_key;
  logic sfr_sel;
  logic sel_second_resume_char;
  logic sel_lsr;
  logic sel_msr;
  logic sel_tcr;
  logic msr_rd;
  logic lsr_rd;
  logic [CW-1:0] halt_lvl;
  logic [CW-1:0] resume_lvl;
  logic [7:0] lsr_val;
  logic [7:0] msr_val;

  // Register selection
  assign enh_key = (CTRL.line_control_reg == uartsf_pkg::UARTSF_LCR_ENH_KEY);
  assign sfr_sel = CTRL.special_feature_reg[uartsf_pkg::UARTSF_SFR_SEL_BIT];
  assign sel_second_resume_char = (REG_ADDR == uartsf_pkg::UARTSF_OFS_SECOND_RESUME_CHAR) && enh_key && !sfr_sel; // RQ5
  assign sel_lsr = (REG_ADDR == uartsf_pkg::UARTSF_OFS_LSR)
    && !CTRL.line_control_reg[uartsf_pkg::UARTSF_LCR_DLAB_BIT];
  assign sel_msr = (REG_ADDR == uartsf_pkg::UARTSF_OFS_MSR) // RQ7
    && !CTRL.line_control_reg[uartsf_pkg::UARTSF_LCR_DLAB_BIT]
    && !CTRL.modem_control_reg[uartsf_pkg::UARTSF_MCR_OP1_BIT] && !sfr_sel;
  assign sel_tcr = (REG_ADDR == uartsf_pkg::UARTSF_OFS_TCR) // RQ15
    && CTRL.enhanced_feature_reg[uartsf_pkg::UARTSF_EFR_ENH_BIT]
    && CTRL.modem_control_reg[uartsf_pkg::UARTSF_MCR_OP1_BIT] && !sfr_sel;
  assign msr_rd = REG_RD && sel_msr;
  assign lsr_rd = REG_RD && sel_lsr;

  // Modem lines, loopback-mapped
  assign loopback = CTRL.modem_control_reg[uartsf_pkg::UARTSF_MCR_LOOP_BIT]; // RQ19
  always_comb begin
    if (loopback) begin
      lines.cd = CTRL.modem_control_reg[uartsf_pkg::UARTSF_MCR_OP2_BIT]; // RQ8
      lines.ri = CTRL.modem_control_reg[uartsf_pkg::UARTSF_MCR_OP1_BIT]; // RQ9
      lines.dsr = CTRL.modem_control_reg[uartsf_pkg::UARTSF_MCR_DTR_BIT]; // RQ10
      lines.cts = CTRL.modem_control_reg[uartsf_pkg::UARTSF_MCR_RTS_BIT]; // RQ11
    end else begin
      lines.cd = !CD_N; // RQ8
      lines.ri = !RI_N; // RQ9
      lines.dsr = !DSR_N; // RQ10
      lines.cts = !CTS_N; // RQ11
    end
  end

  uartsf_err_track #(
    .DEPTH(DEPTH),
    .CW(CW)
  ) u_err_track (
    .clk(CLK_SYS),
    .rst(RST),
    .sw_rst(SW_RESET),
    .push(RX_PUSH),
    .push_err(RX_PUSH_ERR),
    .pop(RX_POP),
    .push_ok(RX_PUSH_OK),
    .full(fifo_full),
    .count(fifo_cnt),
    .head_err(head_err),
    .any_err(any_err)
  );

  uartsf_msr_delta u_msr_delta (
    .clk(CLK_SYS),
    .rst(RST),
    .sw_rst(SW_RESET),
    .lines(lines),
    .clr(msr_rd),
    .delta(delta)
  );

  // Read values
  always_comb begin
    lsr_val = 8'h00;
    lsr_val[uartsf_pkg::UARTSF_LSR_ERR_BIT] = any_err; // RQ20
    lsr_val[uartsf_pkg::UARTSF_LSR_BRK_BIT] = head_err.brk;
    lsr_val[uartsf_pkg::UARTSF_LSR_FE_BIT] = head_err.fe; // RQ1
    lsr_val[uartsf_pkg::UARTSF_LSR_PE_BIT] = head_err.pe; // RQ2
    lsr_val[uartsf_pkg::UARTSF_LSR_OE_BIT] = st_reg.overrun; // RQ3
    lsr_val[uartsf_pkg::UARTSF_LSR_DR_BIT] = (fifo_cnt != '0); // RQ4
    msr_val = {lines.cd, lines.ri, lines.dsr, lines.cts, delta};
  end

  // Levels scaled by four
  assign halt_lvl = CW'({st_reg.rx_halt_resume_levels[3:0], 2'b00});
  assign resume_lvl = CW'({st_reg.rx_halt_resume_levels[7:4], 2'b00});

  always_comb begin
    st_next = st_reg;
    st_next.xon_p = 1'b0;
    st_next.xoff_p = 1'b0;
    if (REG_RD) begin
      if (sel_lsr) begin
        st_next.rdata = lsr_val;
      end else if (sel_msr) begin
        st_next.rdata = msr_val;
      end else if (sel_second_resume_char) begin
        st_next.rdata = st_reg.second_resume_char;
      end else if (sel_tcr) begin
        st_next.rdata = st_reg.rx_halt_resume_levels;
      end else begin
        st_next.rdata = 8'h00;
      end
    end
    if (REG_WR && sel_second_resume_char) begin
      st_next.second_resume_char = REG_WDATA; // RQ5
    end
    if (REG_WR && sel_tcr) begin
      st_next.rx_halt_resume_levels = REG_WDATA; // RQ15
    end
    // Overrun: set wins over the clear by reading
    st_next.overrun = (st_reg.overrun && !lsr_rd) || (RX_PUSH && fifo_full); // RQ3
    // Flow thresholds; a zero halt level disables halting
    if (!AUTO_RTS_EN && !AUTO_SWFLOW_EN) begin
      st_next.halted = 1'b0;
    end else if (!st_reg.halted) begin
      if (st_reg.rx_halt_resume_levels[3:0] != 4'h0 && fifo_cnt >= halt_lvl) begin
        st_next.halted = 1'b1; // RQ17
        st_next.xoff_p = AUTO_SWFLOW_EN; // RQ17
      end
    end else if (fifo_cnt <= resume_lvl) begin
      st_next.halted = 1'b0; // RQ16
      st_next.xon_p = AUTO_SWFLOW_EN; // RQ16
    end
    if (loopback) begin
      st_next.rts_n = 1'b1;
    end else if (AUTO_RTS_EN) begin
      st_next.rts_n = st_next.halted; // RQ16 RQ17
    end else begin
      st_next.rts_n = !CTRL.modem_control_reg[uartsf_pkg::UARTSF_MCR_RTS_BIT];
    end
    st_next.irq = MSR_IRQ_EN && (|delta); // RQ12 RQ13 RQ14
    if (SW_RESET) begin
      st_next = ST_RST;
      st_next.second_resume_char = st_reg.second_resume_char; // RQ6
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      st_reg <= ST_RST; // RQ6
    end else begin
      st_reg <= st_next;
    end
  end

  assign REG_RDATA = st_reg.rdata;
  assign RTS_N = st_reg.rts_n;
  assign XON_SEND = st_reg.xon_p;
  assign XOFF_SEND = st_reg.xoff_p;
  assign MSR_IRQ = st_reg.irq;
  assign SECOND_RESUME_CHAR = st_reg.second_resume_char;

  ovr_set_a: assert property (@(posedge CLK_SYS) disable iff (RST) // RQ3
    RX_PUSH && fifo_full && !RX_POP && !SW_RESET |=> st_reg.overrun && $stable(fifo_cnt))
    else $error("overrun not flagged or full push stored");

  ready_read_a: assert property (@(posedge CLK_SYS) disable iff (RST) // RQ4
    lsr_rd && !SW_RESET |=> REG_RDATA[0] == ($past(fifo_cnt) != '0))
    else $error("data ready bit wrong");

  frame_read_a: assert property (@(posedge CLK_SYS) disable iff (RST) // RQ1
    lsr_rd && !SW_RESET |=> REG_RDATA[3] == $past(head_err.fe))
    else $error("framing bit wrong");

  parity_read_a: assert property (@(posedge CLK_SYS) disable iff (RST) // RQ2
    lsr_rd && !SW_RESET |=> REG_RDATA[2] == $past(head_err.pe))
    else $error("parity bit wrong");

  err_sum_a: assert property (@(posedge CLK_SYS) disable iff (RST) // RQ20
    lsr_rd && !SW_RESET |=> REG_RDATA[7] == $past(any_err))
    else $error("error summary bit wrong");

  second_resume_char_write_a: assert property (@(posedge CLK_SYS) disable iff (RST) // RQ5
    REG_WR && sel_second_resume_char && !SW_RESET |=> SECOND_RESUME_CHAR == $past(REG_WDATA))
    else $error("second resume char not written");

  second_resume_char_keep_a: assert property (@(posedge CLK_SYS) disable iff (RST) // RQ6
    SW_RESET |=> $stable(SECOND_RESUME_CHAR))
    else $error("second resume char changed by software reset");

  tcr_write_a: assert property (@(posedge CLK_SYS) disable iff (RST) // RQ15
    REG_WR && sel_tcr && !SW_RESET |=> st_reg.rx_halt_resume_levels == $past(REG_WDATA))
    else $error("level register not written");

  msr_loop_a: assert property (@(posedge CLK_SYS) disable iff (RST) // RQ19
    msr_rd && loopback && !SW_RESET
    |=> REG_RDATA[7:4] == $past({CTRL.modem_control_reg[3], CTRL.modem_control_reg[2], CTRL.modem_control_reg[0], CTRL.modem_control_reg[1]}))
    else $error("loopback modem status mapping wrong");

  msr_norm_a: assert property (@(posedge CLK_SYS) disable iff (RST) // RQ8
    msr_rd && !loopback && !SW_RESET
    |=> REG_RDATA[7:4] == ~$past({CD_N, RI_N, DSR_N, CTS_N}))
    else $error("modem status not inverted inputs");

  ring_edge_a: assert property (@(posedge CLK_SYS) disable iff (RST) // RQ13
    !loopback && $past(!loopback) && $rose(RI_N) && !SW_RESET |=> delta[2])
    else $error("ring delta missed");

  cd_edge_a: assert property (@(posedge CLK_SYS) disable iff (RST) // RQ12
    $changed(lines.cd) && !SW_RESET ##1 !SW_RESET |=> MSR_IRQ == $past(MSR_IRQ_EN))
    else $error("carrier change interrupt wrong");

  delta_clear_a: assert property (@(posedge CLK_SYS) disable iff (RST) // RQ22
    msr_rd && $stable(lines) |=> delta == 4'h0)
    else $error("delta flags not cleared by read");

  halt_rts_a: assert property (@(posedge CLK_SYS) disable iff (RST) // RQ17
    AUTO_RTS_EN && !loopback && !SW_RESET && !st_reg.halted && st_reg.rx_halt_resume_levels[3:0] != 4'h0
    && fifo_cnt >= halt_lvl |=> RTS_N && st_reg.halted)
    else $error("halt level did not deassert RTS");

  resume_xon_a: assert property (@(posedge CLK_SYS) disable iff (RST) // RQ16
    AUTO_SWFLOW_EN && !SW_RESET && st_reg.halted && fifo_cnt <= resume_lvl
    |=> XON_SEND ##1 !XON_SEND)
    else $error("resume level did not send resume char");
endmodule : uartsf_status

// ### dv/uartsf_modem_model.sv
// Remote modem model driving the active-low modem status lines.
// Assumes the bench sets the wanted active-high line states and a response lag.
`timescale 1ns/100ps
module uartsf_modem_model (
  input wire logic clk,
  input wire uartsf_pkg::uartsf_modem_t want,
  input wire logic [1:0] lag,
  output uartsf_pkg::uartsf_modem_t lines_n
);
  uartsf_pkg::uartsf_modem_t pend = 4'h0;
  uartsf_pkg::uartsf_modem_t drv = 4'hF;
  logic [1:0] cnt = 2'h0;
  assign lines_n = drv;
  // Lines follow the wanted states after the lag, prompt or slow
  always @(posedge clk) begin
    if (want != pend) begin
      pend <= want;
      cnt <= lag;
    end else if (cnt != 2'h0) begin
      cnt <= cnt - 2'h1;
    end else begin
      drv <= ~pend;
    end
  end
endmodule : uartsf_modem_model

// ### dv/tb_top.sv
// Self-checking bench for the UART status and flow-threshold block.
// Assumes the modem model stands on the modem lines; FIFO depth set to 8.
`timescale 1ns/100ps
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sw_rst = 1'b0;
  logic [3:0] addr = 4'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  uartsf_pkg::uartsf_ctrl_t ctrl = 32'h0;
  logic push = 1'b0;
  uartsf_pkg::uartsf_rxerr_t perr = 3'h0;
  logic pop = 1'b0;
  logic push_ok;
  uartsf_pkg::uartsf_modem_t mlines;
  uartsf_pkg::uartsf_modem_t want = 4'h0;
  logic [1:0] lag = 2'h0;
  logic irq_en = 1'b0;
  logic irq;
  logic arts = 1'b0;
  logic asw = 1'b0;
  logic rts_n;
  logic xoff;
  logic xon;
  logic [7:0] second_resume_char;
  int n_fail = 0;
  int checked = 0;

  always #2.5 clk = ~clk;

  uartsf_modem_model modem (.clk(clk), .want(want), .lag(lag), .lines_n(mlines));

  uartsf_status #(.DEPTH(8)) dut (
    .CLK_SYS(clk), .RST(rst), .SW_RESET(sw_rst), .REG_ADDR(addr), .REG_WR(wr),
    .REG_RD(rd), .REG_WDATA(wdata), .REG_RDATA(rdata), .CTRL(ctrl), .RX_PUSH(push),
    .RX_PUSH_ERR(perr), .RX_POP(pop), .RX_PUSH_OK(push_ok), .CD_N(mlines.cd),
    .RI_N(mlines.ri), .DSR_N(mlines.dsr), .CTS_N(mlines.cts), .MSR_IRQ_EN(irq_en),
    .MSR_IRQ(irq), .AUTO_RTS_EN(arts), .AUTO_SWFLOW_EN(asw), .RTS_N(rts_n),
    .XOFF_SEND(xoff), .XON_SEND(xon), .SECOND_RESUME_CHAR(second_resume_char)
  );

  task automatic test_done;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic set_ctrl(input logic [7:0] l, m, s, e);
    @(posedge clk);
    ctrl <= {l, m, s, e};
  endtask : set_ctrl

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask : rd_chk

  task automatic rx_push(input uartsf_pkg::uartsf_rxerr_t e);
    @(posedge clk);
    push <= 1'b1;
    perr <= e;
    @(posedge clk);
    push <= 1'b0;
  endtask : rx_push

  task automatic rx_pop;
    @(posedge clk);
    pop <= 1'b1;
    @(posedge clk);
    pop <= 1'b0;
  endtask : rx_pop

  task automatic t_reset_and_char;
    rd_chk(4'h6, 8'h00);
    rd_chk(4'h5, 8'h00);
    set_ctrl(8'hBF, 8'h00, 8'h00, 8'h00);
    wr_reg(4'h5, 8'hA5);
    rd_chk(4'h5, 8'hA5);
    set_ctrl(8'hBF, 8'h00, 8'h04, 8'h00);
    wr_reg(4'h5, 8'h3C);
    rd_chk(4'h5, 8'h00);
    set_ctrl(8'hBF, 8'h00, 8'h00, 8'h00);
    @(posedge clk);
    sw_rst <= 1'b1;
    @(posedge clk);
    sw_rst <= 1'b0;
    rd_chk(4'h5, 8'hA5);
    chk(second_resume_char, 8'hA5);
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    rd_chk(4'h5, 8'h00);
    set_ctrl(8'h00, 8'h00, 8'h00, 8'h00);
  endtask : t_reset_and_char

  task automatic t_rx_errors;
    rx_push(3'b010);
    rx_push(3'b001);
    rx_push(3'b100);
    rx_push(3'b000);
    rd_chk(4'h5, 8'h89);
    rx_pop;
    rd_chk(4'h5, 8'h85);
    rx_pop;
    rd_chk(4'h5, 8'h91);
    rx_pop;
    rd_chk(4'h5, 8'h01);
    rx_pop;
    rd_chk(4'h5, 8'h00);
  endtask : t_rx_errors

  task automatic t_flow;
    set_ctrl(8'h00, 8'h04, 8'h00, 8'h10);
    wr_reg(4'h6, 8'h12);
    rd_chk(4'h6, 8'h12);
    @(posedge clk);
    arts <= 1'b1;
    asw <= 1'b1;
    repeat (7) rx_push(3'b000);
    tick(3);
    chk({7'h0, xoff}, 8'h00);
    rx_push(3'b000);
    tick(1);
    chk({6'h0, rts_n, xoff}, 8'h03);
    tick(1);
    chk({7'h0, xoff}, 8'h00);
    repeat (3) rx_pop;
    tick(3);
    chk({6'h0, rts_n, xon}, 8'h02);
    rx_pop;
    tick(1);
    chk({6'h0, rts_n, xon}, 8'h01);
    repeat (4) rx_pop;
    @(posedge clk);
    arts <= 1'b0;
    asw <= 1'b0;
  endtask : t_flow

  task automatic t_overrun;
    set_ctrl(8'h00, 8'h00, 8'h00, 8'h00);
    repeat (8) rx_push(3'b000);
    @(posedge clk);
    push <= 1'b1;
    #1;
    chk({7'h0, push_ok}, 8'h00);
    @(posedge clk);
    push <= 1'b0;
    rd_chk(4'h5, 8'h03);
    rd_chk(4'h5, 8'h01);
    repeat (8) rx_pop;
    rd_chk(4'h5, 8'h00);
  endtask : t_overrun

  task automatic t_modem;
    @(posedge clk);
    irq_en <= 1'b1;
    want <= 4'b1001;
    tick(8);
    chk({7'h0, irq}, 8'h01);
    rd_chk(4'h6, 8'h99);
    rd_chk(4'h6, 8'h90);
    tick(2);
    chk({7'h0, irq}, 8'h00);
    want <= 4'b1101;
    tick(8);
    rd_chk(4'h6, 8'hD0);
    want <= 4'b1001;
    tick(8);
    rd_chk(4'h6, 8'h94);
    lag <= 2'h3;
    want <= 4'b1011;
    tick(10);
    rd_chk(4'h6, 8'hB2);
    want <= 4'b0000;
    tick(10);
    rd_chk(4'h6, 8'h0B);
    set_ctrl(8'h00, 8'h04, 8'h00, 8'h00);
    rd_chk(4'h6, 8'h00);
    set_ctrl(8'h00, 8'h00, 8'h04, 8'h00);
    rd_chk(4'h6, 8'h00);
  endtask : t_modem

  task automatic t_loopback;
    set_ctrl(8'h00, 8'h19, 8'h00, 8'h00);
    want <= 4'b0100;
    tick(10);
    rd_chk(4'h6, 8'hAA);
    set_ctrl(8'h00, 8'h1A, 8'h00, 8'h00);
    tick(3);
    rd_chk(4'h6, 8'h93);
    want <= 4'b0000;
    tick(10);
    set_ctrl(8'h00, 8'h00, 8'h00, 8'h00);
    tick(3);
    rd_chk(4'h6, 8'h09);
  endtask : t_loopback

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_reset_and_char;
    t_rx_errors;
    t_flow;
    t_overrun;
    t_modem;
    t_loopback;
    test_done;
  end

  initial begin
    #50000;
    n_fail++;
    test_done;
  end
endmodule : tb_top
